/* cac_addr_match.sv */
// Purpose: Select and deselect decision for an addressed select command
// Assumes: Command arrives from logic on the same clock
// Notes:   Combinational
`timescale 1ns/1ps
`default_nettype none
module cac_addr_match (
  // Command and state
  input  wire cac_pkg::cac_sel_cmd_s cmd,
  input  wire logic [15:0]           card_addr,
  input  wire logic                  selected,
  // Decision
  output logic                       publish_valid,
  output logic                       next_selected
);

  // ==========================================================
  // Claim and select
  always_comb begin
    publish_valid = (card_addr != cac_pkg::CAC_CADDR_BCAST);
    next_selected = selected;
    if (cmd.valid) begin
      if (cmd.addr == cac_pkg::CAC_CADDR_BCAST) begin
        next_selected = 1'b0;
      end else begin
        next_selected = publish_valid && (cmd.addr == card_addr);
      end
    end
  end

endmodule
`default_nettype wire

/* cac_cfg_word.sv */
// Purpose: Builds the fixed 64-bit card configuration word
// Assumes: Values are fixed when the card is built
// Notes:   Pure wiring of parameters into fields
`timescale 1ns/1ps
`default_nettype none
module cac_cfg_word #(
  parameter logic [3:0]  SPEC_VERSION  = cac_pkg::CAC_SPEC_V200,
  parameter logic        ERASE_LEVEL   = 1'b0,
  parameter logic        HIGH_CAPACITY = 1'b1,
  parameter logic [1:0]  CARD_KIND     = cac_pkg::CAC_KIND_REGULAR,
  parameter logic        SEC_OPTIONAL  = 1'b1,
  parameter logic [31:0] MFR_WORD      = 32'h00000000
) (
  // Configuration word
  output logic [63:0] cfg
);

  logic       sec_on;
  logic [2:0] sec_code;

  // ==========================================================
  // Security support
  always_comb begin
    sec_on = (CARD_KIND == cac_pkg::CAC_KIND_REGULAR) || SEC_OPTIONAL;
    if (!sec_on) begin
      sec_code = cac_pkg::CAC_SEC_NONE;
    end else if (HIGH_CAPACITY) begin
      sec_code = cac_pkg::CAC_SEC_V200;
    end else begin
      sec_code = cac_pkg::CAC_SEC_V101;
    end
  end

  // ==========================================================
  // Field layout
  always_comb begin
    cfg = 64'h0000000000000000;
    cfg[cac_pkg::CAC_CFG_LAYOUT_HI:cac_pkg::CAC_CFG_LAYOUT_LO] = cac_pkg::CAC_LAYOUT_V10;
    cfg[cac_pkg::CAC_CFG_SPEC_HI:cac_pkg::CAC_CFG_SPEC_LO]     = SPEC_VERSION;
    cfg[cac_pkg::CAC_CFG_ERASE]                                = ERASE_LEVEL;
    cfg[cac_pkg::CAC_CFG_SEC_HI:cac_pkg::CAC_CFG_SEC_LO]       = sec_code;
    cfg[cac_pkg::CAC_CFG_BUS_HI:cac_pkg::CAC_CFG_BUS_LO]       = cac_pkg::CAC_BUS_WIDTHS;
    cfg[cac_pkg::CAC_CFG_RSV_HI:cac_pkg::CAC_CFG_RSV_LO]       = cac_pkg::CAC_CFG_RSV_VAL;
    cfg[cac_pkg::CAC_CFG_MFR_HI:cac_pkg::CAC_CFG_MFR_LO]       = MFR_WORD;
  end

endmodule
`default_nettype wire

/* cac_host_model.sv */
// Purpose: Card bus host that issues select commands
// Assumes: Same clock as the card registers
// Notes:   Address lines show inverted data when idle
`timescale 1ns/1ps
`default_nettype none
module cac_host_model (
  // Clock
  input  wire logic                    aclk,
  // Card side
  input  wire cac_pkg::cac_card_info_s card_info,
  output cac_pkg::cac_sel_cmd_s        sel_cmd
);
  initial sel_cmd = '0;
  // ==========================================================
  // One-cycle select pulse
  task automatic select(input logic [15:0] a);
    @(posedge aclk);
    sel_cmd <= '{valid: 1'b1, addr: a};
    @(posedge aclk);
    sel_cmd <= '{valid: 1'b0, addr: ~a};
  endtask
  // Select by the address the card published
  task automatic select_own();
    select(card_info.card_addr);
  endtask
endmodule
`default_nettype wire

/* cac_pkg.sv */
// Purpose: Shared constants and types of the card address and configuration registers
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes:   All offsets, fields, resets and encodings are named here
package cac_pkg;

  // ==========================================================
  // Bus widths and responses
  localparam int          CAC_ADDR_W    = 8;
  localparam int          CAC_DATA_W    = 32;
  localparam int          CAC_STRB_W    = 4;
  localparam logic [1:0]  CAC_RESP_OKAY = 2'h0;
  localparam logic [1:0]  CAC_RESP_SLV  = 2'h2;

  // ==========================================================
  // Register offsets
  localparam logic [7:0]  CAC_OFF_CADDR  = 8'h00;
  localparam logic [7:0]  CAC_OFF_DRV    = 8'h04;
  localparam logic [7:0]  CAC_OFF_CFG_LO = 8'h08;
  localparam logic [7:0]  CAC_OFF_CFG_HI = 8'h0C;
  localparam logic [7:0]  CAC_OFF_STATUS = 8'h10;

  // Decoded register index
  localparam logic [2:0]  CAC_IDX_NONE   = 3'h0;
  localparam logic [2:0]  CAC_IDX_CADDR  = 3'h1;
  localparam logic [2:0]  CAC_IDX_DRV    = 3'h2;
  localparam logic [2:0]  CAC_IDX_CFG_LO = 3'h3;
  localparam logic [2:0]  CAC_IDX_CFG_HI = 3'h4;
  localparam logic [2:0]  CAC_IDX_STATUS = 3'h5;

  // ==========================================================
  // Reset values and reserved address
  localparam logic [15:0] CAC_CADDR_RST   = 16'h0000;
  localparam logic [15:0] CAC_DRV_RST     = 16'h0404;
  localparam logic [15:0] CAC_CADDR_BCAST = 16'h0000;

  // Status register bits
  localparam int          CAC_ST_DRV_PRES = 0;
  localparam int          CAC_ST_SELECTED = 1;
  localparam int          CAC_ST_PUBLISH  = 2;

  // ==========================================================
  // Configuration word fields
  localparam int          CAC_CFG_LAYOUT_HI = 63;
  localparam int          CAC_CFG_LAYOUT_LO = 60;
  localparam int          CAC_CFG_SPEC_HI   = 59;
  localparam int          CAC_CFG_SPEC_LO   = 56;
  localparam int          CAC_CFG_ERASE     = 55;
  localparam int          CAC_CFG_SEC_HI    = 54;
  localparam int          CAC_CFG_SEC_LO    = 52;
  localparam int          CAC_CFG_BUS_HI    = 51;
  localparam int          CAC_CFG_BUS_LO    = 48;
  localparam int          CAC_CFG_RSV_HI    = 47;
  localparam int          CAC_CFG_RSV_LO    = 32;
  localparam int          CAC_CFG_MFR_HI    = 31;
  localparam int          CAC_CFG_MFR_LO    = 0;

  // Field encodings
  localparam logic [3:0]  CAC_LAYOUT_V10   = 4'h0;
  localparam logic [3:0]  CAC_SPEC_V101    = 4'h0;
  localparam logic [3:0]  CAC_SPEC_V110    = 4'h1;
  localparam logic [3:0]  CAC_SPEC_V200    = 4'h2;
  localparam logic [2:0]  CAC_SEC_NONE     = 3'h0;
  localparam logic [2:0]  CAC_SEC_V101     = 3'h2;
  localparam logic [2:0]  CAC_SEC_V200     = 3'h3;
  localparam logic [3:0]  CAC_BUS_WIDTHS   = 4'h5;
  localparam logic [15:0] CAC_CFG_RSV_VAL  = 16'h0000;

  // Card kinds
  localparam logic [1:0]  CAC_KIND_REGULAR = 2'h0;
  localparam logic [1:0]  CAC_KIND_ROM     = 2'h1;
  localparam logic [1:0]  CAC_KIND_OTP     = 2'h2;

  // ==========================================================
  // Handshake states
  typedef enum logic [1:0] {
    CAC_WR_IDLE = 2'b01,
    CAC_WR_RESP = 2'b10
  } cac_wr_e;

  typedef enum logic [1:0] {
    CAC_RD_IDLE = 2'b01,
    CAC_RD_DATA = 2'b10
  } cac_rd_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } cac_sel_cmd_s;

  typedef struct packed {
    logic [15:0] card_addr;
    logic        publish_valid;
    logic        selected;
    logic        driver_stage_present;
    logic [15:0] drive_setting;
  } cac_card_info_s;

endpackage

/* cac_regs.sv */
// Purpose: Card address, driver stage and configuration registers on AXI4-Lite
// Assumes: Select commands come from a card bus decoder on aclk
// Notes:   One write and one read outstanding; answers one cycle after take
//
// What this block does
// - Writable 16-bit card address, published to host
// - Card address resets to all zeros
// - Zero address deselects all; never claimed
// - Optional 16-bit driver stage, resets 0x404
// - Card data flag reports driver stage presence
// - Presence flag 0 absent, 1 present
// - 64-bit configuration word, read-only, fixed
// - Configuration word field layout as specified
// - Layout version reads 0
// - Spec version encoded 0, 1, 2
// - Erase level bit chosen by vendor
// - Security version encoded 0, 2, 3
// - Regular writable cards must support security
// - High capacity 3, standard capacity 2
// - Bus widths field reads 0101
`timescale 1ns/1ps
`default_nettype none
module cac_regs #(
  parameter logic        DRV_STAGE_PRESENT = 1'b1,
  parameter logic [3:0]  SPEC_VERSION      = cac_pkg::CAC_SPEC_V200,
  parameter logic        ERASE_LEVEL       = 1'b0,
  parameter logic        HIGH_CAPACITY     = 1'b1,
  parameter logic [1:0]  CARD_KIND         = cac_pkg::CAC_KIND_REGULAR,
  parameter logic        SEC_OPTIONAL      = 1'b1,
  parameter logic [31:0] MFR_WORD          = 32'h00000000
) (
  // Clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // Write address channel
  input  wire logic [cac_pkg::CAC_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                     awprot,
  input  wire logic                           awvalid,
  output logic                                awready,
  // Write data channel
  input  wire logic [cac_pkg::CAC_DATA_W-1:0] wdata,
  input  wire logic [cac_pkg::CAC_STRB_W-1:0] wstrb,
  input  wire logic                           wvalid,
  output logic                                wready,
  // Write response channel
  output logic [1:0]                          bresp,
  output logic                                bvalid,
  input  wire logic                           bready,
  // Read address channel
  input  wire logic [cac_pkg::CAC_ADDR_W-1:0] araddr,
  input  wire logic [2:0]                     arprot,
  input  wire logic                           arvalid,
  output logic                                arready,
  // Read data channel
  output logic [cac_pkg::CAC_DATA_W-1:0]      rdata,
  output logic [1:0]                          rresp,
  output logic                                rvalid,
  input  wire logic                           rready,
  // Card bus side
  input  wire cac_pkg::cac_sel_cmd_s          sel_cmd,
  output cac_pkg::cac_card_info_s             card_info
);

  // ==========================================================
  // State
  typedef struct packed {
    cac_pkg::cac_wr_e               wr;
    cac_pkg::cac_rd_e               rd;
    logic                           aw_held;
    logic [cac_pkg::CAC_ADDR_W-1:0] aw_addr;
    logic                           w_held;
    logic [cac_pkg::CAC_DATA_W-1:0] w_data;
    logic [cac_pkg::CAC_STRB_W-1:0] w_strb;
    logic [1:0]                     bresp;
    logic [cac_pkg::CAC_DATA_W-1:0] rdata;
    logic [1:0]                     rresp;
    logic [15:0]                    caddr;
    logic [15:0]                    drv;
    logic                           selected;
  } cac_state_s;

  localparam cac_state_s CAC_STATE_RST = '{
    wr:       cac_pkg::CAC_WR_IDLE,
    rd:       cac_pkg::CAC_RD_IDLE,
    aw_held:  1'b0,
    aw_addr:  8'h00,
    w_held:   1'b0,
    w_data:   32'h00000000,
    w_strb:   4'h0,
    bresp:    cac_pkg::CAC_RESP_OKAY,
    rdata:    32'h00000000,
    rresp:    cac_pkg::CAC_RESP_OKAY,
    caddr:    cac_pkg::CAC_CADDR_RST,
    drv:      cac_pkg::CAC_DRV_RST,
    selected: 1'b0
  };

  cac_state_s  s;
  cac_state_s  next_s;
  logic [63:0] cfg;
  logic        publish_valid;
  logic        next_selected;
  logic [31:0] status_word;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] cac_decode(input logic [cac_pkg::CAC_ADDR_W-1:0] a);
    logic [cac_pkg::CAC_ADDR_W-1:0] w;
    begin
      w = {a[cac_pkg::CAC_ADDR_W-1:2], 2'h0};
      case (w)
        cac_pkg::CAC_OFF_CADDR:  cac_decode = cac_pkg::CAC_IDX_CADDR;
        cac_pkg::CAC_OFF_DRV:    cac_decode = cac_pkg::CAC_IDX_DRV;
        cac_pkg::CAC_OFF_CFG_LO: cac_decode = cac_pkg::CAC_IDX_CFG_LO;
        cac_pkg::CAC_OFF_CFG_HI: cac_decode = cac_pkg::CAC_IDX_CFG_HI;
        cac_pkg::CAC_OFF_STATUS: cac_decode = cac_pkg::CAC_IDX_STATUS;
        default:                 cac_decode = cac_pkg::CAC_IDX_NONE;
      endcase
    end
  endfunction

  function automatic logic [15:0] cac_merge16(
    input logic [15:0] old_v,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] v;
    begin
      v = old_v;
      if (strb[0]) begin
        v[7:0] = data[7:0];
      end
      if (strb[1]) begin
        v[15:8] = data[15:8];
      end
      cac_merge16 = v;
    end
  endfunction

  // ==========================================================
  // Sub-blocks
  cac_cfg_word #(
    .SPEC_VERSION  (SPEC_VERSION),
    .ERASE_LEVEL   (ERASE_LEVEL),
    .HIGH_CAPACITY (HIGH_CAPACITY),
    .CARD_KIND     (CARD_KIND),
    .SEC_OPTIONAL  (SEC_OPTIONAL),
    .MFR_WORD      (MFR_WORD)
  ) u_cfg (
    .cfg (cfg)
  );

  cac_addr_match u_match (
    .cmd           (sel_cmd),
    .card_addr     (s.caddr),
    .selected      (s.selected),
    .publish_valid (publish_valid),
    .next_selected (next_selected)
  );

  // ==========================================================
  // Status word
  always_comb begin
    status_word = 32'h00000000;
    status_word[cac_pkg::CAC_ST_DRV_PRES] = DRV_STAGE_PRESENT;
    status_word[cac_pkg::CAC_ST_SELECTED] = s.selected;
    status_word[cac_pkg::CAC_ST_PUBLISH]  = publish_valid;
  end

  // ==========================================================
  // Handshake outputs
  always_comb begin
    awready = (s.wr == cac_pkg::CAC_WR_IDLE) && !s.aw_held;
    wready  = (s.wr == cac_pkg::CAC_WR_IDLE) && !s.w_held;
    bvalid  = (s.wr == cac_pkg::CAC_WR_RESP);
    bresp   = s.bresp;
    arready = (s.rd == cac_pkg::CAC_RD_IDLE);
    rvalid  = (s.rd == cac_pkg::CAC_RD_DATA);
    rdata   = s.rdata;
    rresp   = s.rresp;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.selected = next_selected;

    // Write channels taken in either order
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end

    // Write commit
    case (s.wr)
      cac_pkg::CAC_WR_IDLE: begin
        if (next_s.aw_held && next_s.w_held) begin
          next_s.bresp = cac_pkg::CAC_RESP_OKAY;
          case (cac_decode(next_s.aw_addr))
            cac_pkg::CAC_IDX_CADDR: begin
              next_s.caddr = cac_merge16(s.caddr, next_s.w_data, next_s.w_strb);
            end
            cac_pkg::CAC_IDX_DRV: begin
              if (DRV_STAGE_PRESENT) begin
                next_s.drv = cac_merge16(s.drv, next_s.w_data, next_s.w_strb);
              end
            end
            cac_pkg::CAC_IDX_CFG_LO,
            cac_pkg::CAC_IDX_CFG_HI,
            cac_pkg::CAC_IDX_STATUS: begin
              next_s.bresp = cac_pkg::CAC_RESP_OKAY;
            end
            default: begin
              next_s.bresp = cac_pkg::CAC_RESP_SLV;
            end
          endcase
          next_s.aw_held = 1'b0;
          next_s.w_held  = 1'b0;
          next_s.wr      = cac_pkg::CAC_WR_RESP;
        end
      end
      cac_pkg::CAC_WR_RESP: begin
        if (bready) begin
          next_s.wr = cac_pkg::CAC_WR_IDLE;
        end
      end
      default: begin
        next_s.wr = cac_pkg::CAC_WR_IDLE;
      end
    endcase

    // Read path
    case (s.rd)
      cac_pkg::CAC_RD_IDLE: begin
        if (arvalid) begin
          next_s.rresp = cac_pkg::CAC_RESP_OKAY;
          next_s.rdata = 32'h00000000;
          case (cac_decode(araddr))
            cac_pkg::CAC_IDX_CADDR: begin
              next_s.rdata[15:0] = s.caddr;
            end
            cac_pkg::CAC_IDX_DRV: begin
              next_s.rdata[15:0] = DRV_STAGE_PRESENT ? s.drv : 16'h0000;
            end
            cac_pkg::CAC_IDX_CFG_LO: begin
              next_s.rdata = cfg[31:0];
            end
            cac_pkg::CAC_IDX_CFG_HI: begin
              next_s.rdata = cfg[63:32];
            end
            cac_pkg::CAC_IDX_STATUS: begin
              next_s.rdata = status_word;
            end
            default: begin
              next_s.rresp = cac_pkg::CAC_RESP_SLV;
            end
          endcase
          next_s.rd = cac_pkg::CAC_RD_DATA;
        end
      end
      cac_pkg::CAC_RD_DATA: begin
        if (rready) begin
          next_s.rd = cac_pkg::CAC_RD_IDLE;
        end
      end
      default: begin
        next_s.rd = cac_pkg::CAC_RD_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= CAC_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Card bus outputs
  always_comb begin
    card_info.card_addr            = s.caddr;
    card_info.publish_valid        = publish_valid;
    card_info.selected             = s.selected;
    card_info.driver_stage_present = DRV_STAGE_PRESENT;
    card_info.drive_setting        = DRV_STAGE_PRESENT ? s.drv : 16'h0000;
  end

endmodule
`default_nettype wire

/* cac_regs_chk.sv */
// Purpose: Port assertions for the card address and configuration registers
// Assumes: One aclk domain, default parameters of cac_regs
// Notes:   Bound to every cac_regs instance
`timescale 1ns/1ps
`default_nettype none
module cac_regs_chk (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic [7:0]              awaddr,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic [31:0]             wdata,
  input wire logic [3:0]              wstrb,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic [7:0]              araddr,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [31:0]             rdata,
  input wire logic                    rvalid,
  input wire logic                    rready,
  // Card side
  input wire cac_pkg::cac_sel_cmd_s   sel_cmd,
  input wire cac_pkg::cac_card_info_s card_info
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Card address and select
  a_reset_vals: assert property ($rose(aresetn) |-> card_info.card_addr == 16'h0000
    && card_info.drive_setting == 16'h0404) else $error("reset values wrong");
  a_addr_write: assert property (awvalid && awready && wvalid && wready && awaddr == 8'h00
    && wstrb == 4'hF |=> {16'h0000, card_info.card_addr} == ($past(wdata) & 32'h0000FFFF))
    else $error("card address not written");
  a_publish: assert property (card_info.publish_valid
    == (card_info.card_addr != 16'h0000)) else $error("publish flag wrong");
  a_own_select: assert property (sel_cmd.valid && sel_cmd.addr == card_info.card_addr
    && card_info.card_addr != 16'h0000 |=> card_info.selected)
    else $error("own address not taken");
  a_zero_desel: assert property (sel_cmd.valid && sel_cmd.addr == 16'h0000
    |=> !card_info.selected) else $error("zero address did not deselect");
  a_other_desel: assert property (sel_cmd.valid && sel_cmd.addr != card_info.card_addr
    |=> !card_info.selected) else $error("foreign address selected");
  a_sel_stable: assert property (!sel_cmd.valid |=> $stable(card_info.selected))
    else $error("selection changed without command");
  a_stage_flag: assert property (card_info.driver_stage_present == 1'b1)
    else $error("driver stage flag wrong");
  // ==========================================================
  // Register bus answers
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write answer late");
  a_cfg_high: assert property (arvalid && arready && araddr == 8'h0C
    |=> rvalid && rdata == 32'h02350000) else $error("config high word wrong");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
endmodule
bind cac_regs cac_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .sel_cmd(sel_cmd), .card_info(card_info));
`default_nettype wire

/* cac_regs_tb.sv */
// Purpose: Self-checking bench of the card address and configuration registers
// Assumes: Default parameters, AXI4-Lite master tasks
// Notes:   Random values from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module cac_regs_tb;
  logic                    aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata, d;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp, r;
  logic [15:0]             lfsr_q, exp_addr;
  cac_pkg::cac_sel_cmd_s   sel_cmd;
  cac_pkg::cac_card_info_s card_info;
  int                      miscompares, checks;

  cac_regs dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sel_cmd(sel_cmd), .card_info(card_info));
  cac_host_model host (.aclk(aclk), .card_info(card_info), .sel_cmd(sel_cmd));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ==========================================================
  // Expectations
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] cfg_hi_exp();
    return {cac_pkg::CAC_LAYOUT_V10, cac_pkg::CAC_SPEC_V200, 1'b0, cac_pkg::CAC_SEC_V200,
            cac_pkg::CAC_BUS_WIDTHS, cac_pkg::CAC_CFG_RSV_VAL};
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [3:0] s);
    return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
  endfunction
  // ==========================================================
  // Checks and bus cycles
  task automatic chk(input string name, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_hs, w_hs, b_hs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end while (!b_hs);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_hs, r_hs, r_seen;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_seen = rvalid;
      r_hs = rvalid && rready;
      v = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_seen) rready <= !r_hs;
    end while (!r_hs);
  endtask
  task automatic sel_chk(input string name, input logic e);
    @(negedge aclk);
    chk(name, {31'h0, e}, {31'h0, card_info.selected});
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_of_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    lfsr_q = 16'h4DFA;
    exp_addr = 16'h0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r); chk("addr reset", {16'h0, cac_pkg::CAC_CADDR_RST}, d);
    rd(8'h04, d, r); chk("drv reset", {16'h0, cac_pkg::CAC_DRV_RST}, d);
    rd(8'h10, d, r); chk("status", 32'h1, d);
    chk("stage flag", 32'h1, {31'h0, card_info.driver_stage_present});
    rd(8'h08, d, r); chk("cfg low", 32'h0, d);
    rd(8'h0C, d, r); chk("cfg high", cfg_hi_exp(), d);
    wr(8'h0C, 32'hFFFFFFFF, 4'hF, r); chk("cfg write resp", 32'h0, {30'h0, r});
    rd(8'h0C, d, r); chk("cfg read only", cfg_hi_exp(), d);
    wr(8'h20, 32'h1, 4'hF, r); chk("unmapped bresp", 32'h2, {30'h0, r});
    rd(8'h20, d, r); chk("unmapped rresp", 32'h2, {30'h0, r});
    host.select(16'h0000); sel_chk("zero no claim", 1'b0);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      exp_addr = merge(exp_addr, lfsr_q, (i == 0) ? 4'h1 : 4'hF);
      wr(8'h00, {~lfsr_q, lfsr_q}, (i == 0) ? 4'h1 : 4'hF, r);
      rd(8'h00, d, r); chk("addr", {16'h0, exp_addr}, d);
      chk("addr pins", {16'h0, exp_addr}, {16'h0, card_info.card_addr});
      chk("publish", {31'h0, exp_addr != 16'h0}, {31'h0, card_info.publish_valid});
      host.select_own(); sel_chk("own select", exp_addr != 16'h0);
      host.select(exp_addr ^ 16'h8000); sel_chk("other deselect", 1'b0);
      host.select_own();
      host.select(16'h0000); sel_chk("zero deselect", 1'b0);
      wr(8'h04, {16'h0, ~lfsr_q}, 4'hF, r);
      rd(8'h04, d, r); chk("drv", {16'h0, ~lfsr_q}, d);
      chk("drive pins", {16'h0, ~lfsr_q}, {16'h0, card_info.drive_setting});
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, d, r); chk("addr second reset", {16'h0, cac_pkg::CAC_CADDR_RST}, d);
    rd(8'h04, d, r); chk("drv second reset", {16'h0, cac_pkg::CAC_DRV_RST}, d);
    end_of_test();
  end
endmodule
`default_nettype wire
